// file: dgc_top.sv
// Purpose: Right playback gain register, gain stages and two-channel compressor
// Assumes: Register port and samples are synchronous to SYS_CLK
// Notes: Left gain, link field and mute arrive as plain inputs from other registers
`timescale 1ns/100ps
module dgc_top
  import dgc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Register port
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Neighbouring control fields
  input wire logic [7:0] LEFT_GAIN,
  input wire logic [1:0] LINK_MODE,
  input wire logic RIGHT_MUTE,
  // Sample stream
  input wire logic IN_VALID,
  input wire dgc_pair_t IN_SAMPLE,
  output logic OUT_VALID,
  output dgc_pair_t OUT_SAMPLE,
  // Status
  output logic [1:0] COMP_ACTIVE
);

  typedef struct packed {
    logic [7:0] right_gain;
    logic [7:0] comp_ctrl;
    logic mute;
    logic [7:0] rdata;
    logic [1:0] active;
    logic out_valid;
    dgc_pair_t out;
    logic wrote_gain;
    logic wrote_ctrl;
  } dgc_top_st_t;

  localparam dgc_top_st_t ST_RST = '{right_gain: RIGHT_GAIN_RST, comp_ctrl: COMP_CTRL_RST,
                                     mute: MUTE_RST, default: '0};

  dgc_top_st_t st_r;
  dgc_top_st_t st_nxt;
  dgc_reg_wr_t wr;

  logic comp_any;
  logic [1:0] link_eff;
  logic [7:0] chan_code [2];
  logic signed [SAMPLE_W-1:0] chan_in [2];
  logic signed [SAMPLE_W-1:0] g_samp [2];
  logic [1:0] g_valid;
  logic [1:0] comp_en;
  logic [23:0] thr_lvl;
  logic [23:0] rel_lvl;
  logic [1:0] act_nxt;
  logic signed [SAMPLE_W-1:0] comp_out [2];

  assign wr = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};

  // Gain selection and linking
  assign comp_any = |comp_en;
  // Linking would fight the per-channel gain reduction, so it is forced off
  assign link_eff = comp_any ? LINK_INDEP : LINK_MODE;
  assign chan_code[0] = (link_eff == LINK_L_FROM_R) ? st_r.right_gain : LEFT_GAIN;
  assign chan_code[1] = (link_eff == LINK_R_FROM_L) ? LEFT_GAIN : st_r.right_gain;
  assign chan_in[0] = IN_SAMPLE.left;
  assign chan_in[1] = IN_SAMPLE.right;

  // Compressor settings
  assign comp_en[0] = st_r.comp_ctrl[COMP_EN_L_BIT];
  assign comp_en[1] = st_r.comp_ctrl[COMP_EN_R_BIT];
  assign thr_lvl = THR_LEVEL[st_r.comp_ctrl[COMP_THR_LSB +: 3]];
  assign rel_lvl = 24'((40'(thr_lvl) * 40'(HYST_FACTOR[st_r.comp_ctrl[COMP_HYST_LSB +: 2]])) >> HYST_FRAC);

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [23:0] mag;
    logic [23:0] cmag;

    dgc_gain_stage u_gain (
      .clk(SYS_CLK),
      .rst(RESET),
      .in_valid(IN_VALID),
      .in_sample(chan_in[ch]),
      .gain_code(chan_code[ch]),
      .out_valid(g_valid[ch]),
      .out_sample(g_samp[ch])
    );

    assign mag = g_samp[ch][SAMPLE_W-1] ? 24'(-g_samp[ch]) : 24'(g_samp[ch]);

    // Engage above threshold, release below threshold less hysteresis or when the channel's compressor is disabled
    always_comb begin
      if (!g_valid[ch]) begin
        act_nxt[ch] = st_r.active[ch];
      end else if (!comp_en[ch]) begin
        act_nxt[ch] = 1'b0;
      end else if (mag > thr_lvl) begin
        act_nxt[ch] = 1'b1;
      end else if (mag < rel_lvl) begin
        act_nxt[ch] = 1'b0;
      end else begin
        act_nxt[ch] = st_r.active[ch];
      end
    end

    // 4:1 slope above the release knee while engaged
    assign cmag = (act_nxt[ch] && mag > rel_lvl) ? 24'(rel_lvl + ((mag - rel_lvl) >> 2)) : mag;
    assign comp_out[ch] = g_samp[ch][SAMPLE_W-1] ? SAMPLE_W'(-signed'(cmag)) : SAMPLE_W'(signed'(cmag));
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.mute = RIGHT_MUTE;
    if (wr.wr && wr.addr == REG_RIGHT_GAIN) begin
      st_nxt.right_gain = wr.wdata;
      st_nxt.wrote_gain = 1'b1;
    end
    if (wr.wr && wr.addr == REG_COMP_CTRL) begin
      st_nxt.comp_ctrl = wr.wdata;
      st_nxt.wrote_ctrl = 1'b1;
    end
    case (REG_ADDR)
      REG_RIGHT_GAIN: st_nxt.rdata = st_r.right_gain;
      REG_COMP_CTRL: st_nxt.rdata = st_r.comp_ctrl;
      default: st_nxt.rdata = 8'h00;
    endcase
    st_nxt.active = act_nxt;
    st_nxt.out_valid = g_valid[0];
    if (g_valid[0]) begin
      st_nxt.out.left = comp_out[0];
      st_nxt.out.right = st_r.mute ? '0 : comp_out[1];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign OUT_VALID = st_r.out_valid;
  assign OUT_SAMPLE = st_r.out;
  assign COMP_ACTIVE = st_r.active;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_gain_reset_zero: assert property (!st_r.wrote_gain |-> st_r.right_gain == RIGHT_GAIN_RST)
    else $error("right gain not at reset value");
  a_gain_write_read: assert property (REG_WR && REG_ADDR == REG_RIGHT_GAIN
    ##1 !REG_WR && REG_ADDR == REG_RIGHT_GAIN |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("right gain readback wrong");
  a_ctrl_reset_val: assert property (!st_r.wrote_ctrl |-> st_r.comp_ctrl == COMP_CTRL_RST && comp_en == 2'b00)
    else $error("compressor control not at reset value");
  a_thr_code_six: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h6 |-> thr_lvl == 24'h0b6871)
    else $error("threshold code 6 not -21 dB");
  a_thr_code_seven: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h7 |-> thr_lvl == 24'h08138b)
    else $error("threshold code 7 not -24 dB");
  a_left_bypass: assert property (!comp_en[0] && g_valid[0] |=> OUT_VALID && !COMP_ACTIVE[0]
    && OUT_SAMPLE.left == $past(g_samp[0])) else $error("left altered while compression off");
  a_right_bypass: assert property (!comp_en[1] && !st_r.mute && g_valid[1] |=> !COMP_ACTIVE[1]
    && OUT_SAMPLE.right == $past(g_samp[1])) else $error("right altered while compression off");
  a_hyst_zero_rel: assert property (st_r.comp_ctrl[COMP_HYST_LSB +: 2] == 2'b00 |-> rel_lvl == thr_lvl)
    else $error("zero hysteresis release level wrong");
  a_hyst_hold: assert property (st_r.active[1] && comp_en[1] && g_valid[1] && g_chan[1].mag >= rel_lvl
    |=> COMP_ACTIVE[1]) else $error("released inside hysteresis band");
  a_comp_unlinked: assert property (comp_any |-> chan_code[1] == st_r.right_gain
    && chan_code[0] == LEFT_GAIN) else $error("gains linked while compressing");
  a_link_left_to_r: assert property (!comp_any && LINK_MODE == LINK_R_FROM_L |-> chan_code[1] == LEFT_GAIN)
    else $error("right did not take left gain");
  a_mute_silence: assert property (st_r.mute && g_valid[1] |=> OUT_VALID && OUT_SAMPLE.right == '0)
    else $error("muted right channel not silent");

  // Register port and read data
  a_gain_write_lands: assert property (REG_WR && REG_ADDR == REG_RIGHT_GAIN
    |=> st_r.right_gain == $past(REG_WDATA))
    else $error("right gain write lost");
  a_ctrl_write_lands: assert property (REG_WR && REG_ADDR == REG_COMP_CTRL
    |=> st_r.comp_ctrl == $past(REG_WDATA))
    else $error("compressor control write lost");
  a_gain_kept: assert property (!(REG_WR && REG_ADDR == REG_RIGHT_GAIN)
    |=> $stable(st_r.right_gain))
    else $error("right gain changed without write");
  a_ctrl_kept: assert property (!(REG_WR && REG_ADDR == REG_COMP_CTRL)
    |=> $stable(st_r.comp_ctrl))
    else $error("compressor control changed without write");
  a_read_gain_reg: assert property (REG_ADDR == REG_RIGHT_GAIN
    |=> REG_RDATA == $past(st_r.right_gain))
    else $error("right gain read data wrong");
  a_read_ctrl_reg: assert property (REG_ADDR == REG_COMP_CTRL
    |=> REG_RDATA == $past(st_r.comp_ctrl))
    else $error("compressor control read data wrong");
  a_read_unmapped: assert property (REG_ADDR != REG_RIGHT_GAIN && REG_ADDR != REG_COMP_CTRL
    |=> REG_RDATA == 8'h00)
    else $error("unmapped address read not zero");

  // Stream timing and gain selection
  a_out_two_cycles: assert property (IN_VALID
    |-> ##2 OUT_VALID)
    else $error("output pair late or missing");
  a_no_stray_out: assert property (!IN_VALID
    |-> ##2 !OUT_VALID)
    else $error("output pair without input");
  a_out_sample_held: assert property (!g_valid[0]
    |=> $stable(OUT_SAMPLE))
    else $error("output pair changed between samples");
  a_active_held: assert property (!g_valid[0] && !g_valid[1]
    |=> $stable(COMP_ACTIVE))
    else $error("compressor state changed without sample");
  a_right_own_code: assert property (!comp_any && LINK_MODE != LINK_R_FROM_L
    |-> chan_code[1] == st_r.right_gain)
    else $error("right channel lost its own gain");
  a_left_own_code: assert property (!comp_any && LINK_MODE != LINK_L_FROM_R
    |-> chan_code[0] == LEFT_GAIN)
    else $error("left channel lost its own gain");
  a_left_from_right: assert property (!comp_any && LINK_MODE == LINK_L_FROM_R
    |-> chan_code[0] == st_r.right_gain)
    else $error("left did not take right gain");
  a_link_code_three: assert property (!comp_any && LINK_MODE == 2'h3
    |-> chan_code[1] == st_r.right_gain && chan_code[0] == LEFT_GAIN)
    else $error("link code 3 not independent");

  // Compressor engage, release, level bounds and mute
  a_left_engage: assert property (comp_en[0] && g_valid[0] && g_chan[0].mag > thr_lvl
    |=> COMP_ACTIVE[0])
    else $error("left did not engage above threshold");
  a_right_engage: assert property (comp_en[1] && g_valid[1] && g_chan[1].mag > thr_lvl
    |=> COMP_ACTIVE[1])
    else $error("right did not engage above threshold");
  a_left_release: assert property (comp_en[0] && g_valid[0] && g_chan[0].mag < rel_lvl
    |=> !COMP_ACTIVE[0])
    else $error("left did not release below hysteresis");
  a_right_release: assert property (comp_en[1] && g_valid[1] && g_chan[1].mag < rel_lvl
    |=> !COMP_ACTIVE[1])
    else $error("right did not release below hysteresis");
  a_left_hyst_hold: assert property (st_r.active[0] && comp_en[0] && g_valid[0] && g_chan[0].mag >= rel_lvl
    |=> COMP_ACTIVE[0])
    else $error("left released inside hysteresis band");
  a_hyst_nonzero: assert property (st_r.comp_ctrl[COMP_HYST_LSB +: 2] != 2'b00
    |-> rel_lvl < thr_lvl)
    else $error("release level not below threshold");
  a_thr_code_zero: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h0
    |-> thr_lvl == 24'h5a9df7)
    else $error("threshold code 0 not -3 dB");
  a_thr_code_one: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h1
    |-> thr_lvl == 24'h402700)
    else $error("threshold code 1 not -6 dB");
  a_thr_code_two: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h2
    |-> thr_lvl == 24'h2d6a7e)
    else $error("threshold code 2 not -9 dB");
  a_thr_code_three: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h3
    |-> thr_lvl == 24'h2026eb)
    else $error("threshold code 3 not -12 dB");
  a_thr_code_four: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h4
    |-> thr_lvl == 24'h16c366)
    else $error("threshold code 4 not -15 dB");
  a_thr_code_five: assert property (st_r.comp_ctrl[COMP_THR_LSB +: 3] == 3'h5
    |-> thr_lvl == 24'h101d43)
    else $error("threshold code 5 not -18 dB");
  // Positive samples only, so the sign flip of the knee math stays out of the bound
  a_left_not_louder: assert property (g_valid[0] && !g_samp[0][SAMPLE_W-1]
    |=> OUT_SAMPLE.left <= $past(g_samp[0]))
    else $error("left output louder than gain stage");
  a_right_not_louder: assert property (g_valid[1] && !g_samp[1][SAMPLE_W-1]
    |=> OUT_SAMPLE.right <= $past(g_samp[1]))
    else $error("right output louder than gain stage");
  a_left_floor: assert property (g_valid[0] && comp_en[0] && !g_samp[0][SAMPLE_W-1]
    && g_chan[0].mag > rel_lvl |=> 24'(OUT_SAMPLE.left) >= $past(rel_lvl))
    else $error("compressed left below release level");
  a_mute_on: assert property (RIGHT_MUTE
    |=> st_r.mute)
    else $error("mute request not taken");
  a_mute_off: assert property (!RIGHT_MUTE
    |=> !st_r.mute)
    else $error("unmute request not taken");

  c_gain_written: cover property (REG_WR && REG_ADDR == REG_RIGHT_GAIN ##1 IN_VALID ##2 OUT_VALID);
  c_comp_engaged: cover property (!COMP_ACTIVE[0] ##1 COMP_ACTIVE[0]);
  c_comp_released: cover property (COMP_ACTIVE[1] ##1 !COMP_ACTIVE[1] && comp_en[1]);
  c_link_used: cover property (!comp_any && LINK_MODE == LINK_R_FROM_L && IN_VALID);
  c_unmuted: cover property (st_r.mute ##1 !st_r.mute ##2 OUT_VALID);

endmodule

// file: dgc_pkg.sv
// Purpose: Shared constants and types for the playback gain and compressor block
// Assumes: 24-bit signed samples, 8-bit register port
// Notes: Gain codes are signed half-decibel steps
package dgc_pkg;

  localparam int SAMPLE_W = 24;

  // Register index on the control port
  localparam logic [7:0] REG_RIGHT_GAIN = 8'h42;
  localparam logic [7:0] REG_COMP_CTRL = 8'h44;

  // Reset values
  localparam logic [7:0] RIGHT_GAIN_RST = 8'h00;
  localparam logic [7:0] COMP_CTRL_RST = 8'h0f;
  localparam logic MUTE_RST = 1'b1;

  // Compressor control field positions
  localparam int COMP_RSVD_BIT = 7;
  localparam int COMP_EN_L_BIT = 6;
  localparam int COMP_EN_R_BIT = 5;
  localparam int COMP_THR_LSB = 2;
  localparam int COMP_HYST_LSB = 0;

  // Gain linking field codes
  localparam logic [1:0] LINK_INDEP = 2'h0;
  localparam logic [1:0] LINK_L_FROM_R = 2'h1;
  localparam logic [1:0] LINK_R_FROM_L = 2'h2;

  // Named gain codes
  localparam logic [7:0] GAIN_CODE_UNITY = 8'h00;
  localparam logic [7:0] GAIN_CODE_HALF = 8'h01;
  localparam logic [7:0] GAIN_CODE_MAX = 8'h30;
  localparam logic [7:0] GAIN_CODE_NEG_HALF = 8'hff;
  localparam logic [7:0] GAIN_CODE_M63 = 8'h82;
  localparam logic [7:0] GAIN_CODE_M63_5 = 8'h81;

  // Code is biased to non-negative, then split into 6 dB octaves of 12 steps
  localparam int GAIN_BIAS = 132;
  localparam int GAIN_STEPS_OCT = 12;
  localparam int GAIN_SHIFT_BASE = 25;
  localparam int GAIN_MANT_FRAC = 14;
  // 10^(r/40) in Q2.14, r = 0..11
  localparam logic [15:0] GAIN_MANT [12] = '{16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5559,
                                             16'h5a67, 16'h5fc2, 16'h656f, 16'h6b72, 16'h71cf, 16'h788e};

  // Threshold levels re full scale, -3 dB to -24 dB in 3 dB steps
  localparam logic [23:0] THR_LEVEL [8] = '{24'h5a9df7, 24'h402700, 24'h2d6a7e, 24'h2026eb,
                                            24'h16c366, 24'h101d43, 24'h0b6871, 24'h08138b};
  // Release factor for 0..3 dB hysteresis, Q1.15
  localparam int HYST_FRAC = 15;
  localparam logic [15:0] HYST_FACTOR [4] = '{16'h8000, 16'h7215, 16'h65ac, 16'h5a9e};

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } dgc_pair_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dgc_reg_wr_t;

endpackage

// file: dgc_gain_stage.sv
// Purpose: One channel of signed half-decibel digital gain
// Assumes: Code and sample are stable in the cycle IN_VALID is high
// Notes: One cycle of latency; output saturates to the sample range
`timescale 1ns/100ps
module dgc_gain_stage
  import dgc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sample in
  input wire logic in_valid,
  input wire logic signed [SAMPLE_W-1:0] in_sample,
  input wire logic [7:0] gain_code,
  // Sample out
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] out_sample
);

  typedef struct packed {
    logic valid;
    logic signed [SAMPLE_W-1:0] sample;
  } dgc_gain_st_t;

  localparam logic signed [SAMPLE_W-1:0] SMAX = 24'sh7fffff;
  localparam logic signed [SAMPLE_W-1:0] SMIN = -24'sh800000;

  dgc_gain_st_t st_r;
  dgc_gain_st_t st_nxt;

  function automatic logic signed [SAMPLE_W-1:0] scale(input logic signed [SAMPLE_W-1:0] x,
                                                       input logic [15:0] m, input int s);
    logic signed [40:0] p;
    p = (41'(x) * 41'(signed'({1'b0, m}))) >>> s;
    return SAMPLE_W'(p);
  endfunction

  always_comb begin
    int ci;
    int q;
    int r;
    logic signed [40:0] prod;
    ci = int'(signed'(gain_code)) + GAIN_BIAS;
    q = ci / GAIN_STEPS_OCT;
    r = ci % GAIN_STEPS_OCT;
    // Octave shift plus a 12-entry mantissa avoids a full 256-entry table
    prod = 41'(in_sample) * 41'(signed'({1'b0, GAIN_MANT[r]}));
    prod = prod >>> (GAIN_SHIFT_BASE - q);
    st_nxt = st_r;
    st_nxt.valid = in_valid;
    if (in_valid) begin
      if (prod > 41'(SMAX)) begin
        st_nxt.sample = SMAX;
      end else if (prod < 41'(SMIN)) begin
        st_nxt.sample = SMIN;
      end else begin
        st_nxt.sample = SAMPLE_W'(prod);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.valid;
  assign out_sample = st_r.sample;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_unity_gain_pass: assert property (in_valid && gain_code == GAIN_CODE_UNITY |=>
    out_valid && out_sample == $past(in_sample)) else $error("unity gain altered sample");
  a_max_boost_x16: assert property (in_valid && gain_code == GAIN_CODE_MAX
    && in_sample < 24'sh040000 && in_sample > -24'sh040000 |=> out_sample == 24'($past(in_sample) * 16))
    else $error("24 dB boost wrong");
  a_half_db_step: assert property (in_valid && gain_code == GAIN_CODE_HALF |=>
    out_sample == scale($past(in_sample), GAIN_MANT[1], GAIN_MANT_FRAC)) else $error("0.5 dB step wrong");
  a_neg_half_db: assert property (in_valid && gain_code == GAIN_CODE_NEG_HALF |=>
    out_sample == scale($past(in_sample), GAIN_MANT[11], GAIN_MANT_FRAC + 1)) else $error("-0.5 dB wrong");
  a_minus_63_db: assert property (in_valid && gain_code == GAIN_CODE_M63 |=>
    out_sample == scale($past(in_sample), GAIN_MANT[6], GAIN_SHIFT_BASE)) else $error("-63 dB wrong");
  a_deepest_atten: assert property (in_valid && gain_code == GAIN_CODE_M63_5 |=>
    out_sample == scale($past(in_sample), GAIN_MANT[5], GAIN_SHIFT_BASE)) else $error("-63.5 dB wrong");

endmodule

// file: dgc_top_tb_top.sv
// Purpose: Self-checking bench for the playback gain and compressor block
// Assumes: Gain judged in dB with a small tolerance; compressed output only bounded
// Notes: Driver notes expectations in a queue, monitor pops one per output
`timescale 1ns/100ps
module dgc_top_tb_top;
  import dgc_pkg::*;
  typedef struct {real e[2]; real lo; logic [1:0] act;} dgc_note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] left_gain = 8'h00;
  logic [1:0] link_mode = 2'h0;
  logic right_mute = 1'b0;
  logic in_valid = 1'b0;
  dgc_pair_t in_sample = '0;
  logic out_valid;
  dgc_pair_t out_sample;
  logic [1:0] comp_active;
  int error_cnt = 0;
  int checks = 0;
  dgc_note_t notes[$];
  real fs = 8388608.0;

  always #25 sys_clk = ~sys_clk;

  dgc_top uut (.SYS_CLK(sys_clk), .RESET(reset), .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .LEFT_GAIN(left_gain), .LINK_MODE(link_mode), .RIGHT_MUTE(right_mute),
    .IN_VALID(in_valid), .IN_SAMPLE(in_sample), .OUT_VALID(out_valid), .OUT_SAMPLE(out_sample),
    .COMP_ACTIVE(comp_active));

  function automatic real db(real d);
    return $pow(10.0, d / 20.0);
  endfunction
  function automatic real mag(real x);
    return (x < 0.0) ? -x : x;
  endfunction
  task automatic fail(string m);
    error_cnt++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at one edge after the address
  task automatic reg_check(logic [7:0] a, logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    checks++;
    if (reg_rdata !== exp) fail($sformatf("reg %h read %h want %h", a, reg_rdata, exp));
  endtask
  // Called at a falling edge; returns after the sample edge so the caller's next change misses it
  task automatic send(int l, int r, real gl, real gr, logic [1:0] act, real lo);
    dgc_note_t n;
    n.e[0] = l * db(gl);
    n.e[1] = r * db(gr);
    n.lo = lo;
    n.act = act;
    in_valid = 1'b1;
    in_sample.left = SAMPLE_W'(l);
    in_sample.right = SAMPLE_W'(r);
    notes.push_back(n);
    @(negedge sys_clk);
  endtask
  task automatic drain(string name);
    int k;
    k = 0;
    if (in_valid) in_valid = 1'b0;
    while (notes.size() > 0 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    if (notes.size() > 0) begin
      fail("output missing");
      end_of_test();
    end else if (name != "") begin
      $display("Test %s done", name);
    end
  endtask
  // Engaged channel: below its input, not below the release level
  task automatic cmp_pair(dgc_note_t n);
    real o[2];
    o[0] = $itor(out_sample.left);
    o[1] = $itor(out_sample.right);
    checks++;
    if (comp_active !== n.act) fail($sformatf("active %b want %b", comp_active, n.act));
    for (int i = 0; i < 2; i++) begin
      if (n.act[i] ? (mag(o[i]) >= mag(n.e[i]) || mag(o[i]) < 0.97 * n.lo) :
          (mag(o[i] - n.e[i]) > 0.03 * mag(n.e[i]) + 3.0)) begin
        fail($sformatf("channel %0d got %0.1f want %0.1f", i, o[i], n.e[i]));
      end
    end
  endtask

  always @(negedge sys_clk) begin
    if (out_valid === 1'b1) begin
      if (notes.size() == 0) fail("unexpected output");
      else cmp_pair(notes.pop_front());
    end
  end

  initial begin
    #3000000;
    fail("timeout");
    end_of_test();
  end

  initial begin
    logic [7:0] codes[6] = '{8'h00, 8'h30, 8'h01, 8'hff, 8'h82, 8'h81};
    real gains[6] = '{0.0, 24.0, 0.5, -0.5, -63.0, -63.5};
    logic [7:0] ev[3] = '{8'h4c, 8'h2c, 8'h0c};
    logic [1:0] ea[3] = '{2'b01, 2'b10, 2'b00};
    logic [7:0] v;
    logic [7:0] rc;
    real lvl;
    int a;
    int b;
    int c;
    void'($urandom(72));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    reg_check(8'h42, 8'h00);
    reg_check(8'h44, 8'h0f);
    reg_check(8'h43, 8'h00);
    drain("reset values");
    for (int i = 0; i < 6; i++) begin
      reg_write(8'h42, codes[i]);
      reg_check(8'h42, codes[i]);
      left_gain = codes[i];
      send(262144, -262144, gains[i], gains[i], 2'b00, 0.0);
      drain("");
    end
    // Legal codes only: reserved ones have no defined gain
    for (int i = 0; i < 10; i++) begin
      rc = 8'($urandom_range(175, 0) - 127);
      reg_write(8'h42, rc);
      for (int j = 0; j < 3; j++) begin
        left_gain = 8'($urandom_range(175, 0) - 127);
        a = $urandom_range(524288, 0) - 262144;
        send(a, -a, $signed(left_gain) * 0.5, $signed(rc) * 0.5, 2'b00, 0.0);
      end
      drain("");
    end
    drain("gain codes");
    right_mute = 1'b1;
    reg_write(8'h42, 8'h00);
    send(100000, 100000, $signed(left_gain) * 0.5, -1000.0, 2'b00, 0.0);
    drain("mute");
    right_mute = 1'b0;
    reg_write(8'h42, 8'hec);
    left_gain = 8'h0c;
    for (int ce = 0; ce < 2; ce++) begin
      reg_write(8'h44, (ce == 1) ? 8'h20 : 8'h00);
      for (int m = 0; m < 4; m++) begin
        link_mode = 2'(m);
        send(100000, -100000, (ce == 0 && m == 1) ? -10.0 : 6.0, (ce == 0 && m == 2) ? 6.0 : -10.0, 2'b00, 0.0);
      end
      drain("");
    end
    drain("gain linking");
    reg_write(8'h42, 8'h00);
    left_gain = 8'h00;
    link_mode = 2'h0;
    for (int t = 0; t < 8; t++) begin
      v = {3'b011, 3'(t), 2'(t)};
      lvl = fs * db(-3.0 * (t + 1));
      a = int'(lvl * db(-2.0));
      b = int'(lvl * db(2.0));
      c = int'(lvl * db(-0.5 * (t % 4)));
      reg_write(8'h44, v);
      reg_check(8'h44, v);
      send(a, -a, 0.0, 0.0, 2'b00, 0.0);
      send(b, -b, 0.0, 0.0, 2'b11, lvl * db(-1.0 * (t % 4)));
      if (t % 4 != 0) send(c, -c, 0.0, 0.0, 2'b11, lvl * db(-1.0 * (t % 4)));
      send(0, 0, 0.0, 0.0, 2'b00, 0.0);
      drain("");
    end
    lvl = fs * db(-12.0);
    b = int'(lvl * db(2.0));
    for (int k = 0; k < 3; k++) begin
      reg_write(8'h44, ev[k]);
      send(b, -b, 0.0, 0.0, ea[k], lvl);
      send(0, 0, 0.0, 0.0, 2'b00, 0.0);
      drain("");
    end
    drain("compressor");
    end_of_test();
  end
endmodule
